// *** cpt_core.sv ***
// CAN power-off, bit timing, timer link and message buffer window
`timescale 1ns/1ns
module cpt_core
  import cpt_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic test_mode,
  input wire logic sleep_active,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic crystal_clock,
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  input wire logic timer_port_pin,
  output logic timer_channel_in,
  output logic frame_pulse,
  output logic wake_detect,
  output logic power_down
);
  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] module_control_0;
  logic [7:0] module_control_1;
  logic [7:0] bus_timing_0;
  logic [7:0] bus_timing_1;
  logic stop_in_wait_bit;
  logic timer_link_enable;
  logic wake_filter_select;
  logic can_clock_select;
  logic [1:0] resync_jump_width;
  logic [5:0] prescale;
  logic [2:0] second_segment_length;
  logic [3:0] first_segment_length;
  logic acc_ok;
  logic in_buf;
  logic [1:0] buf_sel;
  logic [3:0] buf_ofs;

  assign stop_in_wait_bit = module_control_0[MC0_STOP_WAIT];
  assign timer_link_enable = module_control_0[MC0_TLINK];
  assign wake_filter_select = module_control_1[MC1_WAKE_FILT];
  assign can_clock_select = module_control_1[MC1_CLK_SEL];
  assign resync_jump_width = bus_timing_0[SJW_HI:SJW_LO];
  assign prescale = bus_timing_0[PRE_HI:0];
  assign second_segment_length = bus_timing_1[TS2_HI:TS2_LO];
  assign first_segment_length = bus_timing_1[TS1_HI:0];

  assign power_down = cpu_stop || (cpu_wait && stop_in_wait_bit);
  assign acc_ok = !power_down;
  assign in_buf = reg_addr[BUF_AREA_BIT];
  assign buf_sel = reg_addr[5:4];
  assign buf_ofs = reg_addr[3:0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      module_control_0 <= MC0_RESET;
      module_control_1 <= '0;
      bus_timing_0 <= BT0_RESET;
      bus_timing_1 <= BT1_RESET;
    end else if (reg_wr && acc_ok && !in_buf) begin
      case (reg_addr)
        REG_MCTL0: module_control_0 <= (reg_wdata & MC0_WMASK);
        REG_MCTL1: module_control_1 <= (reg_wdata & MC1_WMASK);
        REG_BTIM0: bus_timing_0 <= reg_wdata;
        REG_BTIM1: bus_timing_1 <= {1'b0, reg_wdata[6:0]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // Clock source, prescaler and bit timing
  // ****************************************
  logic crys_prev;
  logic src_tick;
  logic [5:0] pre_cnt;
  logic tq_tick;
  logic [4:0] tq_cnt;
  logic [4:0] bit_end;
  logic [4:0] sample_at;
  logic rx_prev;
  logic rx_edge;
  logic bit_tick;
  logic sample_tick;
  logic in_frame;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      crys_prev <= 1'b0;
    end else begin
      crys_prev <= crystal_clock;
    end
  end

  // Core clock counts every system clock cycle as a source tick
  assign src_tick = can_clock_select ? (crystal_clock && !crys_prev)
                                     : 1'b1;
  assign tq_tick = src_tick && (pre_cnt == prescale);
  assign sample_at = 5'(first_segment_length) + 5'h1;
  assign rx_edge = rx_prev && !can_rx_pin;
  assign sample_tick = tq_tick && (tq_cnt == sample_at);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_cnt <= '0;
    end else if (power_down) begin
      pre_cnt <= '0;
    end else if (tq_tick) begin
      pre_cnt <= '0;
    end else if (src_tick) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= can_rx_pin;
    end
  end

  // Bit length is sync + seg1 + seg2, extended by the jump width
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tq_cnt <= '0;
      bit_end <= '0;
    end else if (power_down) begin
      tq_cnt <= '0;
      bit_end <= '0;
    end else if (rx_edge && (!in_frame || tq_cnt > sample_at)) begin
      tq_cnt <= '0;
      bit_end <= sample_at + 5'(second_segment_length) + 5'h1;
    end else if (rx_edge && tq_cnt != '0 && tq_cnt <= sample_at) begin
      bit_end <= bit_end + 5'(resync_jump_width) + 5'h1;
    end else if (tq_tick) begin
      if (tq_cnt >= bit_end) begin
        tq_cnt <= '0;
        bit_end <= sample_at + 5'(second_segment_length) + 5'h1;
      end else begin
        tq_cnt <= tq_cnt + 1'b1;
      end
    end
  end

  assign bit_tick = tq_tick && (tq_cnt >= bit_end);

  // ****************************************
  // Receive engine and frame pulse
  // ****************************************
  cpt_rx_state_t rx_state;
  logic [2:0] run_len;
  logic run_lvl;
  logic [2:0] bit_idx;
  logic [7:0] shift;
  logic push_valid;
  logic push_ready;
  logic frame_done;
  logic frame_err;
  logic pulse_arm;
  logic stuff_bit;

  assign in_frame = (rx_state != CPT_IDLE);
  assign stuff_bit = (run_len == STUFF_RUN) && (rx_state == CPT_FRAME);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state <= CPT_IDLE;
      run_len <= '0;
      run_lvl <= 1'b1;
      bit_idx <= '0;
      shift <= '0;
      push_valid <= 1'b0;
      frame_done <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      push_valid <= 1'b0;
      frame_done <= 1'b0;
      frame_err <= 1'b0;
      if (power_down || sleep_active) begin
        rx_state <= CPT_IDLE;
        run_len <= '0;
        bit_idx <= '0;
      end else if (sample_tick) begin
        run_lvl <= can_rx_pin;
        run_len <= (can_rx_pin == run_lvl && run_len != EOF_RUN) ?
                   run_len + 1'b1 : 3'h1;
        case (rx_state)
          CPT_IDLE: begin
            if (!can_rx_pin) begin
              rx_state <= CPT_FRAME;
              bit_idx <= '0;
            end
          end
          CPT_FRAME: begin
            if (stuff_bit && can_rx_pin == run_lvl) begin
              if (can_rx_pin) begin
                rx_state <= CPT_EOF;
              end else begin
                rx_state <= CPT_IDLE;
                frame_err <= 1'b1;
              end
            end else if (!stuff_bit) begin
              shift <= {shift[6:0], can_rx_pin};
              bit_idx <= bit_idx + 1'b1;
              if (bit_idx == 3'h7) begin
                push_valid <= 1'b1;
              end
            end
          end
          CPT_EOF: begin
            if (!can_rx_pin) begin
              rx_state <= CPT_IDLE;
              frame_err <= 1'b1;
            end else if (run_len == EOF_RUN - 3'h1) begin
              rx_state <= CPT_IDLE;
              frame_done <= 1'b1;
            end
          end
          default: rx_state <= CPT_IDLE;
        endcase
      end
    end
  end

  // Pulse starts after end-of-frame, ends on the second bit tick (one to two bit times)
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_pulse <= 1'b0;
      pulse_arm <= 1'b0;
    end else if (power_down) begin
      frame_pulse <= 1'b0;
      pulse_arm <= 1'b0;
    end else if (frame_done) begin
      frame_pulse <= 1'b1;
      pulse_arm <= 1'b0;
    end else if (bit_tick && frame_pulse) begin
      if (pulse_arm) begin
        frame_pulse <= 1'b0;
      end
      pulse_arm <= 1'b1;
    end
  end

  assign timer_channel_in = timer_link_enable ? frame_pulse
                                              : timer_port_pin;

  // Transmit output held recessive in every mode; power-off does not act on it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      can_tx_pin <= 1'b1;
    end else begin
      can_tx_pin <= 1'b1;
    end
  end

  // ****************************************
  // Wake-up glitch filter
  // ****************************************
  logic [$clog2(WAKE_FILT_CYC+1)-1:0] filt_cnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt_cnt <= '0;
      wake_detect <= 1'b0;
    end else begin
      wake_detect <= 1'b0;
      if (!sleep_active || power_down || can_rx_pin) begin
        filt_cnt <= '0;
      end else if (!wake_filter_select) begin
        wake_detect <= 1'b1;
      end else if (filt_cnt == $bits(filt_cnt)'(WAKE_FILT_CYC)) begin
        wake_detect <= 1'b1;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  // ****************************************
  // Message buffers
  // ****************************************
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [3:0] bg_idx;
  logic bg_ready;
  logic copy_pend;
  logic [7:0] bg_buf [FRAME_BYTES];
  logic [7:0] fg_buf [FRAME_BYTES];
  logic [7:0] tx_buf [3][TX_BYTES];
  logic tx_wr;

  assign bg_ready = (bg_idx < 4'(FRAME_BYTES)) && !copy_pend;

  cpt_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(power_down),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(shift),
    .out_valid(fifo_valid),
    .out_ready(bg_ready),
    .out_data(fifo_data)
  );

  // Background index; copy to foreground waits for the FIFO to drain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bg_idx <= '0;
      copy_pend <= 1'b0;
    end else if (power_down || frame_err || (push_valid && !push_ready)) begin
      bg_idx <= '0;
      copy_pend <= 1'b0;
    end else if (copy_pend && !fifo_valid) begin
      copy_pend <= 1'b0;
      bg_idx <= '0;
    end else begin
      if (frame_done) begin
        copy_pend <= 1'b1;
      end
      if (fifo_valid && bg_ready) begin
        bg_idx <= bg_idx + 1'b1;
      end
    end
  end

  // Buffer storage carries no reset
  always_ff @(posedge clk_sys) begin
    if (fifo_valid && bg_ready) begin
      bg_buf[bg_idx] <= fifo_data;
    end
    if (copy_pend && !fifo_valid && !power_down) begin
      fg_buf <= bg_buf;
    end
  end

  assign tx_wr = reg_wr && acc_ok && in_buf && buf_sel != BUF_RX;

  always_ff @(posedge clk_sys) begin
    if (tx_wr && buf_ofs <= OFS_PRIO) begin
      tx_buf[buf_sel - 2'h1][buf_ofs] <= reg_wdata;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (!in_buf) begin
      case (reg_addr)
        REG_MCTL0: next_rdata = module_control_0;
        REG_MCTL1: next_rdata = module_control_1;
        REG_BTIM0: next_rdata = bus_timing_0;
        REG_BTIM1: next_rdata = bus_timing_1;
        default: next_rdata = '0;
      endcase
    end else if (buf_sel == BUF_RX) begin
      if (buf_ofs < OFS_LEN) begin
        next_rdata = test_mode ? bg_buf[buf_ofs] : fg_buf[buf_ofs];
      end else if (buf_ofs == OFS_LEN) begin
        next_rdata = {4'h0, (test_mode ? bg_buf[buf_ofs][3:0]
                                       : fg_buf[buf_ofs][3:0])};
      end
    end else if (buf_ofs < OFS_LEN || buf_ofs == OFS_PRIO) begin
      next_rdata = tx_buf[buf_sel - 2'h1][buf_ofs];
    end else if (buf_ofs == OFS_LEN) begin
      next_rdata = {4'h0, tx_buf[buf_sel - 2'h1][buf_ofs][3:0]};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd && acc_ok) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : cpt_core

// *** cpt_pkg.sv ***
// Constants for the CAN power, timing and message buffer block
package cpt_pkg;
  // ****************************************
  // Register window
  // ****************************************
  localparam int ADDR_W = 7;
  localparam logic [6:0] REG_MCTL0 = 7'h00;
  localparam logic [6:0] REG_MCTL1 = 7'h01;
  localparam logic [6:0] REG_BTIM0 = 7'h02;
  localparam logic [6:0] REG_BTIM1 = 7'h03;
  localparam int BUF_AREA_BIT = 6;
  localparam logic [1:0] BUF_RX = 2'h0;
  localparam logic [3:0] OFS_LEN = 4'hC;
  localparam logic [3:0] OFS_PRIO = 4'hD;
  localparam logic [3:0] LEN_MASK = 4'hF;
  localparam int FRAME_BYTES = 13;
  localparam int TX_BYTES = 14;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int MC0_STOP_WAIT = 5;
  localparam int MC0_TLINK = 3;
  localparam int MC1_WAKE_FILT = 2;
  localparam int MC1_CLK_SEL = 0;
  localparam logic [7:0] MC0_RESET = 8'h20;
  localparam logic [7:0] MC0_WMASK = 8'h28;
  localparam logic [7:0] MC1_WMASK = 8'h05;
  localparam logic [7:0] BT0_RESET = 8'h00;
  localparam logic [7:0] BT1_RESET = 8'h23;
  localparam int SJW_HI = 7;
  localparam int SJW_LO = 6;
  localparam int PRE_HI = 5;
  localparam int TS2_HI = 6;
  localparam int TS2_LO = 4;
  localparam int TS1_HI = 3;
  // ****************************************
  // Frame and filter timing
  // ****************************************
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] EOF_RUN = 3'h7;
  localparam int CLK_MHZ = 50;
  localparam int WAKE_FILT_NS = 2000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    CPT_IDLE = 2'b00,
    CPT_FRAME = 2'b01,
    CPT_EOF = 2'b10
  } cpt_rx_state_t;
endpackage : cpt_pkg

// *** cpt_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module cpt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : cpt_fifo

// *** cpt_core_props.sv ***
// Checker on the ports of the CAN power and buffer block
`timescale 1ns/1ns
module cpt_props
  import cpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic test_mode,
  input wire logic sleep_active,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic crystal_clock,
  input wire logic can_rx_pin,
  input wire logic can_tx_pin,
  input wire logic timer_port_pin,
  input wire logic timer_channel_in,
  input wire logic frame_pulse,
  input wire logic wake_detect,
  input wire logic power_down
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // *****
  // Register window
  // *****
  sequence tx_wr_s;
    reg_wr && !power_down && reg_addr == 7'h50;
  endsequence
  sequence tx_rd_s;
    reg_rd && !reg_wr && !power_down && reg_addr == 7'h50;
  endsequence
  tx_rdback_a: assert property (
    tx_wr_s ##1 tx_rd_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("tx buffer read back differs");
  pd_read_a: assert property (
    reg_rd && power_down |=> reg_rdata == 8'h00)
    else $error("read answered while powered down");
  unused_rd_a: assert property (
    reg_rd && !power_down && reg_addr[6:4] >= 3'h5 && reg_addr[3:1] == 3'h7
    |=> reg_rdata == 8'h00)
    else $error("unused buffer byte reads nonzero");
  len_hi_a: assert property (
    reg_rd && !power_down && reg_addr[6] && reg_addr[3:0] == 4'hC
    |=> reg_rdata[7:4] == 4'h0)
    else $error("length byte upper nibble nonzero");
  // *****
  // Power, pulse and wake
  // *****
  pd_stop_a: assert property (cpu_stop |-> power_down)
    else $error("stop mode without power down");
  tx_idle_a: assert property (power_down |-> can_tx_pin)
    else $error("tx pin dominant while powered down");
  pd_abort_a: assert property (
    power_down |=> !$rose(frame_pulse))
    else $error("frame pulse while powered down");
  pulse_min_a: assert property (
    $rose(frame_pulse) |-> frame_pulse [*7])
    else $error("frame pulse too short");
  pulse_end_a: assert property (
    $rose(frame_pulse) |-> ##[1:1000] !frame_pulse)
    else $error("frame pulse never ends");
  link_low_a: assert property (
    !frame_pulse && !timer_port_pin |-> !timer_channel_in)
    else $error("timer input high with no source");
  link_high_a: assert property (
    frame_pulse && timer_port_pin |-> timer_channel_in)
    else $error("timer input low with both sources");
  wake_sleep_a: assert property (!sleep_active |=> !wake_detect)
    else $error("wake outside sleep");
endmodule : cpt_props

bind cpt_core cpt_props u_props (
  .clk_sys(clk_sys), .rst(rst), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
  .test_mode(test_mode), .sleep_active(sleep_active), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .crystal_clock(crystal_clock),
  .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin),
  .timer_port_pin(timer_port_pin), .timer_channel_in(timer_channel_in),
  .frame_pulse(frame_pulse), .wake_detect(wake_detect),
  .power_down(power_down)
);

// *** cpt_can_node.sv ***
// Behavioural CAN node driving the receive line
`timescale 1ns/1ns
module cpt_can_node (
  input wire logic clk_sys,
  output logic can_rx_pin
);
  initial can_rx_pin = 1'b1;
  task automatic drive_bit(input logic lvl, input int bc);
    can_rx_pin = lvl;
    repeat (bc) @(negedge clk_sys);
  endtask : drive_bit
  // Start bit, 13 bytes MSB first, then recessive end field
  task automatic send_frame(input logic [103:0] body, input int bc);
    drive_bit(1'b0, bc);
    for (int i = 103; i >= 0; i--) begin
      drive_bit(body[i], bc);
    end
    for (int i = 0; i < 12; i++) begin
      drive_bit(1'b1, bc);
    end
  endtask : send_frame
  task automatic glitch(input int n);
    drive_bit(1'b0, n);
    can_rx_pin = 1'b1;
  endtask : glitch
endmodule : cpt_can_node

// *** cpt_core_tb_top.sv ***
// Testbench for the CAN power and buffer block
`timescale 1ns/1ns
module cpt_core_tb_top
  import cpt_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic crystal_clock = 1'b0;
  logic cpu_stop, cpu_wait, test_mode, sleep_active;
  logic reg_rd, reg_wr, timer_port_pin;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic can_rx_pin, can_tx_pin, timer_channel_in;
  logic frame_pulse, wake_detect, power_down, fp_d;
  logic [103:0] body = {{6{16'h5AA5}}, 8'h5A};
  int error_cnt = 0;
  int samples_checked = 0;
  int pulse_cnt = 0;
  int pulse_len = 0;
  int link_hits = 0;
  int wake_cnt = 0;
  always #10 clk_sys = ~clk_sys;
  always #40 crystal_clock = ~crystal_clock;
  cpt_core dut (
    .clk_sys(clk_sys), .rst(rst), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
    .test_mode(test_mode), .sleep_active(sleep_active), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .crystal_clock(crystal_clock),
    .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin),
    .timer_port_pin(timer_port_pin), .timer_channel_in(timer_channel_in),
    .frame_pulse(frame_pulse), .wake_detect(wake_detect),
    .power_down(power_down)
  );
  cpt_can_node node (.clk_sys(clk_sys), .can_rx_pin(can_rx_pin));
  // *****
  // Monitors and helpers
  // *****
  always @(posedge clk_sys) begin
    fp_d <= frame_pulse;
    if (frame_pulse === 1'b1 && fp_d !== 1'b1) pulse_cnt <= pulse_cnt + 1;
    if (frame_pulse === 1'b1) pulse_len <= (fp_d === 1'b1) ? pulse_len + 1 : 1;
    if (frame_pulse === 1'b1 && timer_channel_in === 1'b1) link_hits++;
    if (wake_detect === 1'b1) wake_cnt++;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), e, reg_rdata);
    @(negedge clk_sys);
  endtask : rdc
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d,
    input logic [7:0] e);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk($sformatf("buf %h", a), e, reg_rdata);
    @(negedge clk_sys);
  endtask : wr_rd
  task automatic rx_frame(input int bc, input int n);
    int c0;
    c0 = pulse_cnt;
    node.send_frame(body, bc);
    repeat (3 * bc) @(negedge clk_sys);
    chk("pulse count", 8'(n), 8'(pulse_cnt - c0));
    chk("pulse width", 8'h01, 8'(pulse_len >= bc && pulse_len <= 2 * bc));
  endtask : rx_frame
  task automatic run_cfg(input logic [7:0] b0, input logic [7:0] b1,
    input int bc);
    wr(REG_BTIM0, b0);
    wr(REG_BTIM1, b1);
    rdc(REG_BTIM0, b0);
    rx_frame(bc, 1);
  endtask : run_cfg
  // *****
  // Scenarios
  // *****
  task automatic t_regs();
    rdc(REG_MCTL0, MC0_RESET);
    rdc(REG_BTIM0, BT0_RESET);
    rdc(REG_BTIM1, BT1_RESET);
    rdc(7'h09, 8'h00);
    rdc(7'h20, 8'h00);
    wr(REG_MCTL0, 8'hFF);
    rdc(REG_MCTL0, MC0_WMASK);
    wr(REG_MCTL0, MC0_RESET);
    $display("test regs done");
  endtask : t_regs
  task automatic t_txbuf();
    logic [7:0] d;
    for (int b = 5; b < 8; b++) begin
      for (int o = 0; o < 16; o++) begin
        d = 8'(o * 17 + b) ^ 8'hC3;
        wr_rd(7'(b * 16 + o), d, o > 13 ? 8'h00 : o == 12 ? d & 8'h0F : d);
      end
    end
    $display("test txbuf done");
  endtask : t_txbuf
  task automatic t_power();
    wr(7'h50, 8'h11);
    sleep_active = 1'b1;
    cpu_stop = 1'b1;
    @(negedge clk_sys);
    chk("stop off", 8'h01, {7'h0, power_down});
    chk("tx pin", 8'h01, {7'h0, can_tx_pin});
    rdc(REG_MCTL0, 8'h00);
    wr(7'h50, 8'h77);
    cpu_stop = 1'b0;
    cpu_wait = 1'b1;
    @(negedge clk_sys);
    chk("wait off", 8'h01, {7'h0, power_down});
    cpu_wait = 1'b0;
    wr(REG_MCTL0, 8'h00);
    cpu_wait = 1'b1;
    @(negedge clk_sys);
    chk("wait on", 8'h00, {7'h0, power_down});
    rdc(7'h50, 8'h11);
    cpu_wait = 1'b0;
    wr(REG_MCTL0, MC0_RESET);
    sleep_active = 1'b0;
    $display("test power done");
  endtask : t_power
  task automatic t_rx();
    rx_frame(8, 1);
    rdc(7'h40, 8'h5A);
    rdc(7'h41, 8'hA5);
    rdc(7'h4C, 8'h0A);
    test_mode = 1'b1;
    rdc(7'h41, 8'hA5);
    test_mode = 1'b0;
    wr(7'h40, 8'h00);
    rdc(7'h40, 8'h5A);
    $display("test rx done");
  endtask : t_rx
  task automatic t_timing();
    run_cfg(8'h01, 8'h23, 16);
    run_cfg(8'h00, 8'h16, 10);
    run_cfg(8'hC0, 8'h23, 8);
    wr(REG_MCTL1, 8'h01);
    rx_frame(32, 1);
    wr(REG_MCTL1, 8'h00);
    $display("test timing done");
  endtask : t_timing
  task automatic t_link();
    int c0;
    timer_port_pin = 1'b0;
    @(negedge clk_sys);
    chk("port route", 8'h00, {7'h0, timer_channel_in});
    timer_port_pin = 1'b1;
    wr(REG_MCTL0, 8'h28);
    chk("link idle", 8'h00, {7'h0, timer_channel_in});
    c0 = link_hits;
    rx_frame(8, 1);
    chk("link pulse", 8'h01, 8'(link_hits > c0));
    wr(REG_MCTL0, MC0_RESET);
    $display("test link done");
  endtask : t_link
  task automatic t_abort();
    int c0;
    c0 = pulse_cnt;
    fork
      node.send_frame(body, 8);
      begin
        repeat (400) @(negedge clk_sys);
        cpu_stop = 1'b1;
      end
    join
    repeat (24) @(negedge clk_sys);
    cpu_stop = 1'b0;
    repeat (24) @(negedge clk_sys);
    chk("aborted pulse", 8'h00, 8'(pulse_cnt - c0));
    $display("test abort done");
  endtask : t_abort
  task automatic t_wake();
    int c0;
    sleep_active = 1'b1;
    wr(REG_MCTL1, 8'h04);
    c0 = wake_cnt;
    node.glitch(WAKE_FILT_CYC / 2);
    repeat (4) @(negedge clk_sys);
    chk("short glitch", 8'h00, 8'(wake_cnt - c0));
    node.glitch(WAKE_FILT_CYC + 20);
    repeat (4) @(negedge clk_sys);
    chk("long glitch", 8'h01, 8'(wake_cnt > c0));
    wr(REG_MCTL1, 8'h00);
    c0 = wake_cnt;
    node.glitch(3);
    repeat (4) @(negedge clk_sys);
    chk("no filter", 8'h01, 8'(wake_cnt > c0));
    sleep_active = 1'b0;
    $display("test wake done");
  endtask : t_wake
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    $display("CHECK FAILED run length expected end seen hang");
    end_of_test();
  end
  initial begin
    {cpu_stop, cpu_wait, test_mode, sleep_active} = 4'h0;
    {reg_rd, reg_wr, timer_port_pin} = 3'h1;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    t_regs();
    t_txbuf();
    t_power();
    t_rx();
    t_timing();
    t_link();
    t_abort();
    t_wake();
    end_of_test();
  end
endmodule : cpt_core_tb_top
